// ---- spm_port.v ----
// Serial peripheral port: pin directions, select modes, byte shifter.
// Assumes link pins are asynchronous to sys_clk and are resolved by the
// testbench from the out/oe pairs. Clock mode: idle low, sample on rise.
//
// What this block does
// - Master drives the master-to-slave data pin; slave takes it as input.
// - Bytes shift most significant bit first on both data pins.
// - Master drives master-to-slave data from shift register top bit.
// - Master takes slave-to-master data as input; slave drives it.
// - Slave-to-master pin floats when disabled or unselected four-wire slave.
// - Three-wire slave always drives slave-to-master pin from top bit.
// - Master makes and drives serial clock; slave receives it.
// - Four-wire slave ignores serial clock while select input is high.
// - Mode 00: three-wire, select unused, slave always selected.
// - Mode 01: four-wire, select is input, low selects the slave.
// - Mode 01 master: select falling edge disables the master function.
// - Mode 1x: select pin is output, level equals lower mode bit.
// - Select routed to a pin in every mode except three-wire.
// - Transfer-done flag set per byte; interrupt requested when enabled.
// - Mode fault clears master and port enables, sets fault flag.
// - Mode 01 slave resets bit counter on each select falling edge.
`timescale 1ns/100ps
`default_nettype none
`include "spm_defines.vh"

module spm_port #(
	parameter SCK_HALF_CYC = `SPM_SCK_HALF_CYC,
	parameter FIFO_DEPTH = `SPM_FIFO_DEPTH
) (
	input wire sys_clk, // System clock
	input wire rst_b, // Asynchronous reset, active low
	input wire cfgWrite, // Pulse: load the three config fields below
	input wire cfgPortEnable, // Port enable bit value
	input wire cfgMasterEnable, // Master enable bit value
	input wire [1:0] cfgSelectMode, // Select mode field value
	input wire intEnable, // Interrupt enable level
	input wire doneClear, // Pulse: clear transfer-done flag
	input wire faultClear, // Pulse: clear mode-fault flag
	input wire [7:0] txData, // Byte to transmit
	input wire txValid, // Byte offered
	output wire txReady, // Transmit buffer can take a byte
	output reg [7:0] rxData, // Last received byte
	output reg rxValid, // Pulse: rxData updated
	output reg portEnable, // Port enable bit state
	output reg masterEnable, // Master enable bit state
	output reg [1:0] selectModeField, // Select mode field state
	output reg transferDoneFlag, // Sticky: a byte completed
	output reg modeFaultFlag, // Sticky: mode fault seen
	output reg irq, // Interrupt request, active high
	input wire sckIn, // Serial clock pin input
	output reg sckOut, // Serial clock drive value
	output reg sckOe, // Serial clock drive enable
	input wire mosiIn, // Master-to-slave pin input
	output reg mosiOut, // Master-to-slave drive value
	output reg mosiOe, // Master-to-slave drive enable
	input wire misoIn, // Slave-to-master pin input
	output reg misoOut, // Slave-to-master drive value
	output reg misoOe, // Slave-to-master drive enable
	input wire slaveSelectNIn, // Select pin input, active low
	output reg slaveSelectNOut, // Select pin drive value
	output reg slaveSelectNOe, // Select pin drive enable
	output reg selectRouted // Select signal mapped to a pin
);

	wire [3:0] pinSync;
	wire sckS;
	wire mosiS;
	wire misoS;
	wire selS;
	wire fifoValid;
	wire [7:0] fifoData;
	reg fifoPop;

	reg [7:0] shift_reg, shift_next;
	reg [2:0] bitCnt_reg, bitCnt_next;
	reg sampled_reg, sampled_next;
	reg loaded_reg, loaded_next;
	reg busy_reg, busy_next;
	reg [`SPM_HALF_W-1:0] half_reg, half_next;
	reg sck_reg, sck_next;
	reg prevSck_reg;
	reg prevSel_reg;
	reg portEn_next, masterEn_next;
	reg [1:0] mode_next;
	reg done_next, fault_next;
	reg [7:0] rxData_next;
	reg rxValid_next;
	reg riseEv, fallEv, inBit, selFall, slaveRole, slaveSel;

	assign sckS = pinSync[0];
	assign mosiS = pinSync[1];
	assign misoS = pinSync[2];
	assign selS = pinSync[3];

	// Four-wire modes use the select pin as an input or an output
	function isFourWire;
		input [1:0] mode;
		begin
			isFourWire = (mode != `SPM_MODE_3WIRE);
		end
	endfunction

	// ==========================================
	// Pin synchronisers
	spm_sync #(
		.W(4)
	) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.asyncIn({slaveSelectNIn, misoIn, mosiIn, sckIn}),
		.syncOut(pinSync)
	);

	// ==========================================
	// Transmit buffer; a full buffer stalls the writer
	spm_fifo #(
		.WIDTH(`SPM_WORD_W),
		.DEPTH(FIFO_DEPTH),
		.AW(`SPM_FIFO_AW)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.inValid(txValid),
		.inReady(txReady),
		.inData(txData),
		.outValid(fifoValid),
		.outReady(fifoPop),
		.outData(fifoData)
	);

	// ==========================================
	// Next-state logic
	always @* begin
		shift_next = shift_reg;
		bitCnt_next = bitCnt_reg;
		sampled_next = sampled_reg;
		loaded_next = loaded_reg;
		busy_next = busy_reg;
		half_next = half_reg;
		sck_next = sck_reg;
		portEn_next = portEnable;
		masterEn_next = masterEnable;
		mode_next = selectModeField;
		done_next = transferDoneFlag & ~doneClear;
		fault_next = modeFaultFlag & ~faultClear;
		rxData_next = rxData;
		rxValid_next = 1'b0;
		fifoPop = 1'b0;
		riseEv = 1'b0;
		fallEv = 1'b0;
		selFall = prevSel_reg & ~selS;
		slaveRole = portEnable & ~masterEnable;
		// Three-wire slave is always selected; four-wire needs select low
		slaveSel = (selectModeField == `SPM_MODE_3WIRE) | ~selS;
		inBit = masterEnable ? misoS : mosiS;

		if (portEnable & masterEnable) begin
			// Master paces its own serial clock
			if (busy_reg) begin
				if (half_reg == {`SPM_HALF_W{1'b0}}) begin
					half_next = SCK_HALF_CYC[`SPM_HALF_W-1:0] - 1'b1;
					sck_next = ~sck_reg;
					riseEv = ~sck_reg;
					fallEv = sck_reg;
				end else begin
					half_next = half_reg - 1'b1;
				end
			end
		end else if (slaveRole & slaveSel) begin
			// Clock edges outside selection are dropped
			riseEv = sckS & ~prevSck_reg;
			fallEv = ~sckS & prevSck_reg;
		end

		if (riseEv) begin
			sampled_next = inBit;
			bitCnt_next = bitCnt_reg + 1'b1;
			if (bitCnt_reg == `SPM_BIT_LAST) begin
				// Byte complete: MSB arrived first, so it sits at the top
				rxData_next = {shift_reg[`SPM_MSB-1:0], inBit};
				rxValid_next = 1'b1;
				done_next = 1'b1;
				loaded_next = 1'b0;
			end
		end
		if (fallEv) begin
			if (bitCnt_reg != `SPM_BIT_FIRST) begin
				shift_next = {shift_reg[`SPM_MSB-1:0], sampled_reg};
			end else if (masterEnable) begin
				busy_next = 1'b0;
				sck_next = 1'b0;
			end
		end

		// Mode 01 slave: select falling edge restarts the byte
		if (slaveRole & isFourWire(selectModeField) & ~selectModeField[`SPM_MODE_HI_BIT] & selFall) begin
			bitCnt_next = `SPM_BIT_FIRST;
		end

		// Reload from the buffer only between bytes
		if (fifoValid & (bitCnt_next == `SPM_BIT_FIRST) & ~fallEv & portEnable) begin
			if (masterEnable & ~busy_reg) begin
				fifoPop = 1'b1;
				shift_next = fifoData;
				busy_next = 1'b1;
				sck_next = 1'b0;
				half_next = SCK_HALF_CYC[`SPM_HALF_W-1:0] - 1'b1;
			end else if (slaveRole & ~loaded_next & ~riseEv) begin
				fifoPop = 1'b1;
				shift_next = fifoData;
				loaded_next = 1'b1;
			end
		end

		if (cfgWrite) begin
			portEn_next = cfgPortEnable;
			masterEn_next = cfgMasterEnable;
			mode_next = cfgSelectMode;
		end

		// Another master took the bus; fault overrides a config write
		if (portEnable & masterEnable & (selectModeField == `SPM_MODE_4WIRE_IN) & selFall) begin
			portEn_next = 1'b0;
			masterEn_next = 1'b0;
			fault_next = 1'b1;
		end

		// Disable or a role change is the only way to resync a three-wire slave counter
		if (~portEn_next | (masterEn_next != masterEnable)) begin
			busy_next = 1'b0;
			sck_next = 1'b0;
			bitCnt_next = `SPM_BIT_FIRST;
			loaded_next = 1'b0;
		end
	end

	// ==========================================
	// State and registered pin outputs
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_reg <= 8'h00;
			bitCnt_reg <= `SPM_BIT_FIRST;
			sampled_reg <= 1'b0;
			loaded_reg <= 1'b0;
			busy_reg <= 1'b0;
			half_reg <= {`SPM_HALF_W{1'b0}};
			sck_reg <= 1'b0;
			prevSck_reg <= 1'b0;
			// Matches the cleared synchroniser, so release shows no false select fall
			prevSel_reg <= 1'b0;
			portEnable <= 1'b0;
			masterEnable <= 1'b0;
			selectModeField <= `SPM_MODE_4WIRE_IN;
			transferDoneFlag <= 1'b0;
			modeFaultFlag <= 1'b0;
			irq <= 1'b0;
			rxData <= 8'h00;
			rxValid <= 1'b0;
			sckOut <= 1'b0;
			sckOe <= 1'b0;
			mosiOut <= 1'b0;
			mosiOe <= 1'b0;
			misoOut <= 1'b0;
			misoOe <= 1'b0;
			slaveSelectNOut <= 1'b1;
			slaveSelectNOe <= 1'b0;
			selectRouted <= 1'b1;
		end else begin
			shift_reg <= shift_next;
			bitCnt_reg <= bitCnt_next;
			sampled_reg <= sampled_next;
			loaded_reg <= loaded_next;
			busy_reg <= busy_next;
			half_reg <= half_next;
			sck_reg <= sck_next;
			prevSck_reg <= sckS;
			prevSel_reg <= selS;
			portEnable <= portEn_next;
			masterEnable <= masterEn_next;
			selectModeField <= mode_next;
			transferDoneFlag <= done_next;
			modeFaultFlag <= fault_next;
			irq <= intEnable & (done_next | fault_next);
			rxData <= rxData_next;
			rxValid <= rxValid_next;
			sckOut <= sck_next;
			sckOe <= portEn_next & masterEn_next;
			mosiOut <= masterEn_next & shift_next[`SPM_MSB];
			mosiOe <= portEn_next & masterEn_next;
			misoOut <= shift_next[`SPM_MSB];
			// Float unless an enabled, selected slave
			misoOe <= portEn_next & ~masterEn_next &
				((mode_next == `SPM_MODE_3WIRE) | ~selS);
			slaveSelectNOut <= mode_next[`SPM_MODE_LO_BIT];
			slaveSelectNOe <= mode_next[`SPM_MODE_HI_BIT];
			selectRouted <= isFourWire(mode_next);
		end
	end

endmodule

`default_nettype wire

// ---- spm_defines.vh ----
// Constants shared by the serial peripheral port design files.
// Assumes it is included by bare name from the port design file.
`ifndef SPM_DEFINES_VH
`define SPM_DEFINES_VH

// ==========================================
// Select-mode field encodings
`define SPM_MODE_3WIRE 2'h0
`define SPM_MODE_4WIRE_IN 2'h1
`define SPM_MODE_HI_BIT 1
`define SPM_MODE_LO_BIT 0

// ==========================================
// Byte framing
`define SPM_WORD_W 8
`define SPM_MSB 7
`define SPM_BIT_LAST 3'h7
`define SPM_BIT_FIRST 3'h0

// ==========================================
// Master serial clock half period, in system clocks
`define SPM_SCK_HALF_CYC 8'h04
`define SPM_HALF_W 8

// ==========================================
// Transmit buffer
`define SPM_FIFO_DEPTH 4
`define SPM_FIFO_AW 2

`endif

// ---- spm_sync.v ----
// Two-flip-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a separate asynchronous level; no bus coherence is given.
`timescale 1ns/100ps
`default_nettype none

module spm_sync #(
	parameter W = 4
) (
	input wire sys_clk, // System clock
	input wire rst_b, // Asynchronous reset, active low
	input wire [W-1:0] asyncIn, // Levels from outside the clock domain
	output reg [W-1:0] syncOut // Synchronised levels
);

	reg [W-1:0] meta_reg;

	// ==========================================
	// Two stages; the first is read only by the second
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= {W{1'b0}};
			syncOut <= {W{1'b0}};
		end else begin
			meta_reg <= asyncIn;
			syncOut <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// ---- spm_fifo.v ----
// Small first-word-fall-through FIFO with valid/ready on both sides.
// Assumes both sides run on sys_clk; depth must be a power of two.
`timescale 1ns/100ps
`default_nettype none

module spm_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire sys_clk, // System clock
	input wire rst_b, // Asynchronous reset, active low
	input wire inValid, // Writer offers a word
	output wire inReady, // FIFO can take a word
	input wire [WIDTH-1:0] inData, // Word written
	output wire outValid, // FIFO holds a word
	input wire outReady, // Reader takes the head word
	output wire [WIDTH-1:0] outData // Head word
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_reg;
	reg [AW-1:0] rdPtr_reg;
	reg [AW:0] count_reg;
	reg ready_reg;
	wire push;
	wire pop;

	// Ready comes from a flop so the writer never sees a combinational full
	assign inReady = ready_reg;
	assign outValid = (count_reg != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_reg];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	// ==========================================
	// Storage; contents need no reset
	always @(posedge sys_clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	// ==========================================
	// Pointers and occupancy
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr_reg <= {AW{1'b0}};
			rdPtr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			ready_reg <= 1'b1;
		end else begin
			if (push) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= rdPtr_reg + 1'b1;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + 1'b1;
				ready_reg <= (count_reg != DEPTH[AW:0] - 1'b1);
			end else if (pop & ~push) begin
				count_reg <= count_reg - 1'b1;
				ready_reg <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// ---- spm_port_properties.sv ----
// Checker for pin directions, select modes and flags of spm_port.
// Assumes it is bound to spm_port and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Properties
module spm_port_properties (
	input wire logic sys_clk, // Clock
	input wire logic rst_b, // Reset
	input wire logic intEnable, // Irq gate
	input wire logic rxValid, // Byte in
	input wire logic portEnable, // Enabled
	input wire logic masterEnable, // Master
	input wire logic [1:0] selectModeField, // Mode
	input wire logic transferDoneFlag, // Done
	input wire logic modeFaultFlag, // Fault
	input wire logic irq, // Request
	input wire logic sckOe, // Clock oe
	input wire logic mosiOe, // Data oe
	input wire logic misoOe, // Reply oe
	input wire logic slaveSelectNIn, // Select in
	input wire logic slaveSelectNOut, // Select out
	input wire logic slaveSelectNOe, // Select oe
	input wire logic selectRouted // Mapped
);
	logic [2:0] selHighCnt_reg;
	// Select must stay high past the synchroniser lag before it counts as settled
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			selHighCnt_reg <= 3'h0;
		else if (!slaveSelectNIn)
			selHighCnt_reg <= 3'h0;
		else if (selHighCnt_reg != 3'h7)
			selHighCnt_reg <= selHighCnt_reg + 3'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	mosi_drive_a: assert property (mosiOe == (portEnable && masterEnable))
		else $error("data out drive wrong");
	sck_drive_a: assert property (sckOe == (portEnable && masterEnable))
		else $error("clock drive wrong");
	miso_float_a: assert property ((!portEnable || masterEnable || (selectModeField == 2'h1 && selHighCnt_reg > 3'h5)) |-> !misoOe)
		else $error("reply line driven while it must float");
	three_wire_drive_a: assert property ((portEnable && !masterEnable && selectModeField == 2'h0) |-> misoOe)
		else $error("three-wire slave not driving");
	sel_output_a: assert property (slaveSelectNOe == selectModeField[1] && (!selectModeField[1] || slaveSelectNOut == selectModeField[0]))
		else $error("select output wrong");
	sel_route_a: assert property (selectRouted == (selectModeField != 2'h0))
		else $error("select routing wrong");
	fault_trip_a: assert property ((portEnable && masterEnable && selectModeField == 2'h1 && $fell(slaveSelectNIn)) |-> ##[1:5] (modeFaultFlag && !portEnable && !masterEnable))
		else $error("mode fault missing");
	irq_follow_a: assert property (1'b1 |=> irq == ($past(intEnable) && (transferDoneFlag || modeFaultFlag)))
		else $error("irq wrong");
	done_with_rx_a: assert property (rxValid |-> transferDoneFlag)
		else $error("done flag missing");
	sck_ignored_a: assert property ((selectModeField == 2'h1 && !masterEnable && selHighCnt_reg > 3'h5) |-> !rxValid)
		else $error("byte taken while unselected");
endmodule

bind spm_port spm_port_properties spm_port_properties_inst (
	.sys_clk(sys_clk), .rst_b(rst_b), .intEnable(intEnable), .rxValid(rxValid),
	.portEnable(portEnable), .masterEnable(masterEnable), .selectModeField(selectModeField),
	.transferDoneFlag(transferDoneFlag), .modeFaultFlag(modeFaultFlag), .irq(irq),
	.sckOe(sckOe), .mosiOe(mosiOe), .misoOe(misoOe), .slaveSelectNIn(slaveSelectNIn),
	.slaveSelectNOut(slaveSelectNOut), .slaveSelectNOe(slaveSelectNOe), .selectRouted(selectRouted)
);
`default_nettype wire

// ---- spm_far_model.sv ----
// Far-side serial device: echoing slave, or master with 125 ns clock.
// Assumes the bench resolves the pins from both parties' enables.
`timescale 1ns/100ps
`default_nettype none

module spm_far_model (
	input wire logic sckPin, // Clock pin
	input wire logic mosiPin, // Data pin
	input wire logic misoPin, // Reply pin
	input wire logic slaveOn, // Act as slave
	output var logic sckDrv, // Clock drive
	output var logic mosiDrv, // Data drive
	output wire logic misoDrv, // Reply drive
	output var logic selNDrv // Select drive
);
	logic [7:0] shiftReg = 8'h96;
	logic inBit = 1'b0;
	initial begin
		sckDrv = 1'b0;
		mosiDrv = 1'b0;
		selNDrv = 1'b1;
	end
	// ==========================================
	// Slave role: sample on rise, shift on fall
	assign misoDrv = shiftReg[7];
	always @(posedge sckPin) begin
		if (slaveOn)
			inBit = mosiPin;
	end
	always @(negedge sckPin) begin
		if (slaveOn)
			shiftReg = {shiftReg[6:0], inBit};
	end
	// ==========================================
	// Master role
	task xfer(input logic [7:0] b, output logic [7:0] got);
		int i;
		selNDrv = 1'b0;
		#125;
		for (i = 7; i >= 0; i--) begin
			mosiDrv = b[i];
			#62.5;
			sckDrv = 1'b1;
			got[i] = misoPin;
			#62.5;
			sckDrv = 1'b0;
		end
		#125;
		selNDrv = 1'b1;
		mosiDrv = ~mosiDrv;
		#125;
	endtask
	task idleClocks(input int c);
		repeat (c) begin
			#62.5;
			sckDrv = 1'b1;
			#62.5;
			sckDrv = 1'b0;
		end
	endtask
	// Selected frame cut short after c clocks, leaving the slave mid-byte
	task partialFrame(input int c);
		selNDrv = 1'b0;
		#125;
		idleClocks(c);
		#125;
		selNDrv = 1'b1;
		#125;
	endtask
	task dropSel;
		selNDrv = 1'b0;
		#200;
		selNDrv = 1'b1;
	endtask
endmodule
`default_nettype wire

// ---- spm_port_test.sv ----
// Self-checking bench for spm_port against the far-side model.
// Assumes the checker and model files are compiled before it.
`timescale 1ns/100ps
`default_nettype none

module spm_port_test;
	logic sys_clk = 1'b0, rst_b = 1'b0, cfgWrite = 1'b0, cfgPortEnable = 1'b0, cfgMasterEnable = 1'b0;
	logic intEnable = 1'b0, doneClear = 1'b0, faultClear = 1'b0, txValid = 1'b0, farSlave = 1'b0;
	logic floatPat = 1'b0;
	logic [1:0] cfgSelectMode = 2'h0;
	logic [7:0] txData = 8'h00, got, k;
	logic txReady, rxValid, portEnable, masterEnable, transferDoneFlag, modeFaultFlag, irq, selectRouted;
	logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, slaveSelectNOut, slaveSelectNOe;
	logic farSck, farMosi, farMiso, farSelN;
	logic [7:0] rxData;
	logic [1:0] selectModeField;
	wire logic sckPin, mosiPin, misoPin, selNPin;
	int mismatches = 0, compares = 0, cycles = 0, n, m, r;
	always #5 sys_clk = ~sys_clk;
	// Released lines toggle so a stale level never reads as valid data
	always @(posedge sys_clk) floatPat <= ~floatPat;
	assign sckPin = sckOe ? sckOut : farSck;
	assign mosiPin = mosiOe ? mosiOut : (farSlave ? floatPat : farMosi);
	assign misoPin = misoOe ? misoOut : (farSlave ? farMiso : floatPat);
	assign selNPin = slaveSelectNOe ? slaveSelectNOut : farSelN;
	spm_port spm_port_inst (.sys_clk(sys_clk), .rst_b(rst_b), .cfgWrite(cfgWrite),
		.cfgPortEnable(cfgPortEnable), .cfgMasterEnable(cfgMasterEnable), .cfgSelectMode(cfgSelectMode),
		.intEnable(intEnable), .doneClear(doneClear), .faultClear(faultClear), .txData(txData),
		.txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .portEnable(portEnable),
		.masterEnable(masterEnable), .selectModeField(selectModeField), .transferDoneFlag(transferDoneFlag),
		.modeFaultFlag(modeFaultFlag), .irq(irq), .sckIn(sckPin), .sckOut(sckOut), .sckOe(sckOe),
		.mosiIn(mosiPin), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoPin), .misoOut(misoOut),
		.misoOe(misoOe), .slaveSelectNIn(selNPin), .slaveSelectNOut(slaveSelectNOut),
		.slaveSelectNOe(slaveSelectNOe), .selectRouted(selectRouted));
	spm_far_model spm_far_model_inst (.sckPin(sckPin), .mosiPin(mosiPin), .misoPin(misoPin),
		.slaveOn(farSlave), .sckDrv(farSck), .mosiDrv(farMosi), .misoDrv(farMiso), .selNDrv(farSelN));
	// ==========================================
	// Tasks
	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cfg(input logic pe, input logic me, input logic [1:0] md);
		@(posedge sys_clk);
		cfgWrite <= 1'b1;
		cfgPortEnable <= pe;
		cfgMasterEnable <= me;
		cfgSelectMode <= md;
		@(posedge sys_clk);
		cfgWrite <= 1'b0;
		repeat (5) @(negedge sys_clk);
	endtask
	task push(input logic [7:0] d);
		@(posedge sys_clk);
		txData <= d;
		txValid <= 1'b1;
		@(posedge sys_clk);
		txValid <= 1'b0;
	endtask
	task waitRx;
		int i;
		@(negedge sys_clk);
		for (i = 0; i < 300 && rxValid !== 1'b1; i++)
			@(negedge sys_clk);
		check(rxValid, 1'b1);
	endtask
	task test_done;
		$display("Comparisons %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard: the whole sequence needs about 1000 cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			mismatches++;
			test_done();
		end
	end
	// ==========================================
	// Sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(negedge sys_clk);
		check(selectModeField, 2'h1);
		check({portEnable, misoOe, mosiOe, sckOe, selectRouted}, 8'h01);
		$display("Test reset finished");
		for (m = 0; m < 4; m++)
			for (r = 0; r < 2; r++)
				if (m < 2 || r == 1) begin
					cfg(1'b1, r[0], m[1:0]);
					check(selectRouted, m != 0);
					check(slaveSelectNOe, m[1]);
					check({mosiOe, sckOe}, {6'h0, r[0], r[0]});
					check(misoOe, r == 0 && m == 0);
					if (m > 1)
						check(slaveSelectNOut, m[0]);
				end
		cfg(1'b0, 1'b0, 2'h0);
		check({misoOe, mosiOe, sckOe}, 8'h00);
		$display("Test mode table finished");
		farSlave = 1'b1;
		@(posedge sys_clk);
		intEnable <= 1'b1;
		cfg(1'b1, 1'b1, 2'h0);
		push(8'hA5);
		push(8'h3C);
		waitRx;
		check(rxData, 8'h96);
		waitRx;
		check(rxData, 8'hA5);
		repeat (12) @(negedge sys_clk);
		check(spm_far_model_inst.shiftReg, 8'h3C);
		check({transferDoneFlag, irq}, 8'h03);
		@(posedge sys_clk);
		doneClear <= 1'b1;
		@(posedge sys_clk);
		doneClear <= 1'b0;
		repeat (2) @(negedge sys_clk);
		check({transferDoneFlag, irq}, 8'h00);
		$display("Test master transfer finished");
		farSlave = 1'b0;
		cfg(1'b1, 1'b1, 2'h1);
		spm_far_model_inst.dropSel();
		check({portEnable, masterEnable, modeFaultFlag, irq}, 8'h03);
		@(posedge sys_clk);
		faultClear <= 1'b1;
		@(posedge sys_clk);
		faultClear <= 1'b0;
		cfg(1'b1, 1'b1, 2'h1);
		check({portEnable, masterEnable, modeFaultFlag}, 8'h06);
		$display("Test mode fault finished");
		cfg(1'b1, 1'b0, 2'h1);
		spm_far_model_inst.partialFrame(3);
		n = 0;
		while (txReady === 1'b1 && n < 8) begin
			push(8'hA0 + n[7:0]);
			@(negedge sys_clk);
			n++;
		end
		check(txReady, 1'b0);
		spm_far_model_inst.idleClocks(8);
		check(transferDoneFlag, 1'b0);
		for (k = 0; k < n; k++) begin
			spm_far_model_inst.xfer(8'h50 + k, got);
			check(got, 8'hA0 + k);
			check(rxData, 8'h50 + k);
		end
		check(txReady, 1'b1);
		$display("Test slave transfer finished");
		test_done();
	end
endmodule
`default_nettype wire
